/* src/hwmon_pkg.sv */
package hwmon_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_ADDR    = 8'h40; // Configuration
  localparam logic [7:0] RSTCTL_ADDR    = 8'h44; // Reset output control
  localparam logic [7:0] INTRCTL_ADDR   = 8'h46; // Intrusion clear control
  localparam logic [7:0] STATUS_ADDR    = 8'h48; // Pin and mode status
  localparam logic [7:0] IRQ_STAT_ADDR  = 8'h4c; // Sticky event status
  localparam logic [7:0] IRQ_EN_ADDR    = 8'h50; // Event enable
  localparam logic [7:0] IRQ_CLR_ADDR   = 8'h54; // Event clear (write only)

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_INT_EN_BIT      = 1;
  localparam int CFG_RST_TRIG_BIT    = 4;
  localparam int CFG_INTR_CLR_BIT    = 6;
  localparam int RSTCTL_EN_BIT       = 7;
  localparam int INTRCTL_CLR_BIT     = 7;
  localparam int ST_ADDR_LOW_BIT     = 0;
  localparam int ST_ADDR_HIGH_BIT    = 1;
  localparam int ST_INTRUSION_BIT    = 2;
  localparam int ST_NAND_MODE_BIT    = 3;
  localparam int ST_INTR_PULSE_BIT   = 4;
  localparam int ST_RST_PULSE_BIT    = 5;
  localparam int ST_EXT_RST_BIT      = 6;
  localparam int EV_INTRUSION_BIT    = 0;
  localparam int EV_INTR_DONE_BIT    = 1;
  localparam int EV_RST_DONE_BIT     = 2;
  localparam int EV_WIDTH            = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_RESET  = 8'h00;
  localparam logic [7:0] RSTCTL_RESET  = 8'h00;
  localparam logic [7:0] INTRCTL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int PULSE_MIN_MS  = 20;
  localparam int PULSE_CYCLES  = (CLK_HZ / 1000) * PULSE_MIN_MS;
  localparam int PULSE_CNT_W   = 22;

endpackage

/* src/od_pulse_timer.sv */
module od_pulse_timer
  import hwmon_pkg::*;
#(
  parameter int unsigned CYCLES = PULSE_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  output logic      active,
  output logic      done
);

  logic [PULSE_CNT_W-1:0] count_reg;
  wire                    last = (count_reg == PULSE_CNT_W'(1));

  // ----------------------------------------------------------------
  // Self-timed pulse: loads on start, ends by itself
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      active    <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !active) begin
        count_reg <= PULSE_CNT_W'(CYCLES);
        active    <= 1'b1;
      end else if (active) begin
        count_reg <= count_reg - PULSE_CNT_W'(1);
        if (last) begin
          active <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end

endmodule // od_pulse_timer

/* src/hwmon_pin_ctrl.sv */
// Register access over APB and the register offsets are this design's own decisions.
module hwmon_pin_ctrl
  import hwmon_pkg::*;
#(
  parameter int unsigned PULSE_LEN = hwmon_pkg::PULSE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        slave_addr_bit_low_in,
  output logic             slave_addr_bit_low_out,
  output logic             slave_addr_bit_low_oe,
  input  wire logic        slave_addr_bit_high,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        sda_drive_low,
  output logic             sda_sampled,
  output logic [1:0]       slave_addr_bits,
  input  wire logic        intrusion_pin_in,
  output logic             intrusion_pin_out,
  output logic             intrusion_pin_oe,
  input  wire logic        nand_tree_select_in,
  input  wire logic        nand_tree_result,
  output logic             analog_out_enable,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  output logic             int_out,
  output logic             int_oe,
  output logic             irq
);
  import hwmon_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] a_lo_sync, a_hi_sync, sda_sync, intr_sync, nand_sync, rst_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_lo_sync <= 2'h0;
      a_hi_sync <= 2'h0;
      sda_sync  <= 2'h3;
      intr_sync <= 2'h0;
      nand_sync <= 2'h0;
      rst_sync  <= 2'h3;
    end else begin
      a_lo_sync <= {a_lo_sync[0], slave_addr_bit_low_in};
      a_hi_sync <= {a_hi_sync[0], slave_addr_bit_high};
      sda_sync  <= {sda_sync[0], sda_in};
      intr_sync <= {intr_sync[0], intrusion_pin_in};
      nand_sync <= {nand_sync[0], nand_tree_select_in};
      rst_sync  <= {rst_sync[0], reset_pin_in};
    end
  end

  wire intrusion_lvl = intr_sync[1];
  wire nand_mode     = nand_sync[1];
  wire ext_reset     = ~rst_sync[1];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]          config_reg, rstctl_reg, intrctl_reg;
  logic [EV_WIDTH-1:0] irq_stat_reg, irq_en_reg;
  logic [1:0]          addr_strap_reg;
  logic                strap_taken_reg;
  logic [1:0]          strap_prime_reg;  // Strap waits until synchronisers hold pin levels
  logic [2:0]          own_rst_sr_reg;   // Own pulse echo still in the reset synchroniser
  logic                intr_lvl_d_reg;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire access     = psel & penable;
  wire wr         = access & pwrite;
  wire hit_cfg    = (paddr == CONFIG_ADDR);
  wire hit_rstctl = (paddr == RSTCTL_ADDR);
  wire hit_intrct = (paddr == INTRCTL_ADDR);
  wire hit_status = (paddr == STATUS_ADDR);
  wire hit_istat  = (paddr == IRQ_STAT_ADDR);
  wire hit_ien    = (paddr == IRQ_EN_ADDR);
  wire hit_iclr   = (paddr == IRQ_CLR_ADDR);
  wire mapped     = hit_cfg | hit_rstctl | hit_intrct | hit_status |
                    hit_istat | hit_ien | hit_iclr;

  // ----------------------------------------------------------------
  // Pulse timers
  // ----------------------------------------------------------------
  logic intr_active, intr_done, rst_active, rst_done;

  wire intr_start = config_reg[CFG_INTR_CLR_BIT] | intrctl_reg[INTRCTL_CLR_BIT];
  wire rst_start  = config_reg[CFG_RST_TRIG_BIT] & rstctl_reg[RSTCTL_EN_BIT];

  od_pulse_timer #(.CYCLES(PULSE_LEN)) intr_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (intr_start),
    .active  (intr_active),
    .done    (intr_done)
  );

  od_pulse_timer #(.CYCLES(PULSE_LEN)) rst_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (rst_start),
    .active  (rst_active),
    .done    (rst_done)
  );

  // Own reset pulse must not reset the registers that fired it
  wire soft_clear = ext_reset & ~rst_active & ~|own_rst_sr_reg;

  // ----------------------------------------------------------------
  // Event detection and status
  // ----------------------------------------------------------------
  wire intr_rise = intrusion_lvl & ~intr_lvl_d_reg;
  wire [EV_WIDTH-1:0] ev_set = {rst_done, intr_done, intr_rise};
  wire [EV_WIDTH-1:0] ev_clr = (wr & hit_iclr) ? pwdata[EV_WIDTH-1:0] : '0;

  wire [7:0] status_val = {1'b0, ext_reset, rst_active, intr_active, nand_mode,
                           intrusion_lvl, addr_strap_reg};

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [31:0] rd_val =
      hit_cfg    ? {24'h0, config_reg} :
      hit_rstctl ? {24'h0, rstctl_reg} :
      hit_intrct ? {24'h0, intrctl_reg} :
      hit_status ? {24'h0, status_val} :
      hit_istat  ? {29'h0, irq_stat_reg} :
      hit_ien    ? {29'h0, irq_en_reg} : 32'h0;

  // ----------------------------------------------------------------
  // Control registers; trigger bits self-clear the cycle after they are set, taken or not
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg  <= CONFIG_RESET;
      rstctl_reg  <= RSTCTL_RESET;
      intrctl_reg <= INTRCTL_RESET;
      irq_en_reg  <= '0;
    end else if (soft_clear) begin
      config_reg  <= CONFIG_RESET;
      rstctl_reg  <= RSTCTL_RESET;
      intrctl_reg <= INTRCTL_RESET;
      irq_en_reg  <= '0;
    end else begin
      if (intr_start) begin
        config_reg[CFG_INTR_CLR_BIT]   <= 1'b0;
        intrctl_reg[INTRCTL_CLR_BIT]   <= 1'b0;
      end
      if (config_reg[CFG_RST_TRIG_BIT]) config_reg[CFG_RST_TRIG_BIT] <= 1'b0;
      if (wr && hit_cfg)    config_reg  <= pwdata[7:0];
      if (wr && hit_rstctl) rstctl_reg  <= pwdata[7:0];
      if (wr && hit_intrct) intrctl_reg <= pwdata[7:0];
      if (wr && hit_ien)    irq_en_reg  <= pwdata[EV_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Sticky events: set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg   <= '0;
      intr_lvl_d_reg <= 1'b0;
      own_rst_sr_reg <= 3'h0;
    end else begin
      intr_lvl_d_reg <= intrusion_lvl;
      own_rst_sr_reg <= {own_rst_sr_reg[1:0], rst_active};
      if (soft_clear) irq_stat_reg <= ev_set;
      else            irq_stat_reg <= (irq_stat_reg & ~ev_clr) | ev_set;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_strap_reg  <= 2'h0;
      strap_taken_reg <= 1'b0;
      strap_prime_reg <= 2'h0;
    end else if (soft_clear) begin
      strap_taken_reg <= 1'b0;
    end else if (!strap_prime_reg[1]) begin
      strap_prime_reg <= {strap_prime_reg[0], 1'b1};
    end else if (!strap_taken_reg && !nand_mode) begin
      addr_strap_reg  <= {a_hi_sync[1], a_lo_sync[1]};
      strap_taken_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // APB answer and pin drivers, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata                 <= 32'h0;
      pready                 <= 1'b0;
      pslverr                <= 1'b0;
      slave_addr_bit_low_out <= 1'b0;
      slave_addr_bit_low_oe  <= 1'b0;
      sda_out                <= 1'b0;
      sda_oe                 <= 1'b0;
      sda_sampled            <= 1'b1;
      slave_addr_bits        <= 2'h0;
      intrusion_pin_out      <= 1'b0;
      intrusion_pin_oe       <= 1'b0;
      analog_out_enable      <= 1'b0;
      reset_pin_out          <= 1'b0;
      reset_pin_oe           <= 1'b0;
      int_out                <= 1'b0;
      int_oe                 <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      pready                 <= psel & ~penable & ~pready;
      pslverr                <= psel & ~penable & ~pready & ~mapped;
      prdata                 <= (psel & ~penable & ~pwrite) ? rd_val : 32'h0;
      slave_addr_bit_low_out <= nand_tree_result;
      slave_addr_bit_low_oe  <= nand_mode;
      sda_out                <= 1'b0;
      sda_oe                 <= sda_drive_low;
      sda_sampled            <= sda_sync[1];
      slave_addr_bits        <= addr_strap_reg;
      intrusion_pin_out      <= 1'b0;
      intrusion_pin_oe       <= intr_active;
      analog_out_enable      <= ~nand_mode;
      reset_pin_out          <= 1'b0;
      reset_pin_oe           <= rst_active;
      int_out                <= 1'b0;
      int_oe                 <= config_reg[CFG_INT_EN_BIT] & |(irq_stat_reg & irq_en_reg);
      irq                    <= |(irq_stat_reg & irq_en_reg);
    end
  end

endmodule // hwmon_pin_ctrl

/* sim/hwmon_pin_ctrl_assertions.sv */
module hwmon_chk #(
  parameter int unsigned PULSE_LEN = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_sampled,
  input wire logic intrusion_pin_oe,
  input wire logic intrusion_pin_out,
  input wire logic reset_pin_oe,
  input wire logic reset_pin_out,
  input wire logic int_out,
  input wire logic int_oe,
  input wire logic irq,
  input wire logic nand_tree_select_in,
  input wire logic nand_tree_result,
  input wire logic slave_addr_bit_low_oe,
  input wire logic slave_addr_bit_low_out,
  input wire logic analog_out_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int ic;
  int rc;

  // High-time counters of both pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ic <= 0;
      rc <= 0;
    end else begin
      ic <= intrusion_pin_oe ? ic + 1 : 0;
      rc <= reset_pin_oe ? rc + 1 : 0;
    end
  end

  // ----
  // Pin properties
  // ----
  property p_od; !sda_out && !intrusion_pin_out && !reset_pin_out && !int_out; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_sda; !sda_in [*4] |-> !sda_sampled; endproperty
  a_sda: assert property (p_sda) else $error("low data line not seen");
  property p_int; int_oe |-> irq; endproperty
  a_int: assert property (p_int) else $error("interrupt pin without cause");
  property p_ilen;
    $fell(intrusion_pin_oe) && $past(presetn) |-> ic == PULSE_LEN;
  endproperty
  a_ilen: assert property (p_ilen) else $error("clear pulse length wrong");
  property p_rlen; $fell(reset_pin_oe) && $past(presetn) |-> rc == PULSE_LEN; endproperty
  a_rlen: assert property (p_rlen) else $error("reset pulse length wrong");
  property p_max; ic <= PULSE_LEN + 1 && rc <= PULSE_LEN + 1; endproperty
  a_max: assert property (p_max) else $error("pulse does not end");
  property p_nand;
    nand_tree_select_in [*5] |-> slave_addr_bit_low_oe && !analog_out_enable;
  endproperty
  a_nand: assert property (p_nand) else $error("test mode not entered");
  property p_ana;
    !nand_tree_select_in [*5] |-> !slave_addr_bit_low_oe && analog_out_enable;
  endproperty
  a_ana: assert property (p_ana) else $error("analog output not restored");
  property p_nout;
    slave_addr_bit_low_oe && $past(slave_addr_bit_low_oe)
      |-> slave_addr_bit_low_out == $past(nand_tree_result);
  endproperty
  a_nout: assert property (p_nout) else $error("test result not driven");

  // Main scenarios reached
  c_intr: cover property ($rose(intrusion_pin_oe));
  c_rst: cover property ($rose(reset_pin_oe));
  c_gate: cover property ($rose(int_oe));
  c_nand: cover property ($rose(slave_addr_bit_low_oe));
endmodule // hwmon_chk

bind hwmon_pin_ctrl hwmon_chk #(.PULSE_LEN(PULSE_LEN)) u_chk (
  .pclk, .presetn, .sda_in, .sda_out, .sda_sampled, .intrusion_pin_oe, .intrusion_pin_out,
  .reset_pin_oe, .reset_pin_out, .int_out, .int_oe, .irq, .nand_tree_select_in,
  .nand_tree_result, .slave_addr_bit_low_oe, .slave_addr_bit_low_out, .analog_out_enable
);

/* sim/far_side_model.sv */
module far_side_model (
  input  wire logic       frame,
  input  wire logic [7:0] data,
  input  wire logic       ev,
  input  wire logic       ext_rst,
  input  wire logic       sda_oe,
  input  wire logic       intrusion_pin_oe,
  input  wire logic       reset_pin_oe,
  output logic            scl,
  output logic            sda_in,
  output logic            intrusion_pin_in,
  output logic            reset_pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] idx;
  logic       cur;
  logic       lat;

  // Host clock runs only in a frame; next bit MSB first on falling edge
  initial begin
    scl = 1'b1;
    idx = 3'h7;
    cur = 1'b1;
    lat = 1'b0;
    #3;
    forever begin
      #80;
      if (!frame) begin
        scl = 1'b1;
        idx = 3'h7;
        cur = 1'b1;
      end else begin
        scl = ~scl;
        if (!scl) begin
          cur = data[idx];
          idx = idx - 3'h1;
        end
      end
    end
  end

  // External latch, cleared while the pin is pulled low
  always @* begin
    if (intrusion_pin_oe) lat = 1'b0;
    else if (ev) lat = 1'b1;
  end

  // Pulled-up lines, low while any party pulls
  assign sda_in = !(sda_oe || (frame && !cur));
  assign intrusion_pin_in = lat && !intrusion_pin_oe;
  assign reset_pin_in = !(reset_pin_oe || ext_rst);
endmodule // far_side_model

/* sim/tb_top.sv */
module tb_top import hwmon_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PLEN = 50;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, hdata;
  logic [31:0] pwdata, prdata, r, d;
  logic        slave_addr_bit_low_in, slave_addr_bit_low_out, slave_addr_bit_low_oe;
  logic        slave_addr_bit_high, sda_in, sda_out, sda_oe, sda_drive_low, sda_sampled;
  logic [1:0]  slave_addr_bits;
  logic        intrusion_pin_in, intrusion_pin_out, intrusion_pin_oe;
  logic        nand_tree_select_in, nand_tree_result, analog_out_enable;
  logic        reset_pin_in, reset_pin_out, reset_pin_oe, int_out, int_oe, irq;
  logic        frame, ev, ext_rst, scl;
  int          seed, n_mismatch, num_checks, m_cfg, m_rst, m_en, m_ev, len;

  // Clock
  always #5 pclk = ~pclk;

  hwmon_pin_ctrl #(.PULSE_LEN(PLEN)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .slave_addr_bit_low_in, .slave_addr_bit_low_out, .slave_addr_bit_low_oe,
    .slave_addr_bit_high, .sda_in, .sda_out, .sda_oe, .sda_drive_low, .sda_sampled,
    .slave_addr_bits, .intrusion_pin_in, .intrusion_pin_out, .intrusion_pin_oe,
    .nand_tree_select_in, .nand_tree_result, .analog_out_enable, .reset_pin_in,
    .reset_pin_out, .reset_pin_oe, .int_out, .int_oe, .irq);
  far_side_model host (.frame, .data(hdata), .ev, .ext_rst, .sda_oe, .intrusion_pin_oe,
    .reset_pin_oe, .scl, .sda_in, .intrusion_pin_in, .reset_pin_in);

  // ----
  // Tasks
  // ----
  task automatic summarize;
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic bump;
    n_mismatch++;
    summarize();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) bump();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
    case (a)
      CONFIG_ADDR: m_cfg = wd & 32'h2;
      RSTCTL_ADDR: m_rst = wd & 32'h80;
      IRQ_EN_ADDR: m_en = wd & 32'h7;
      IRQ_CLR_ADDR: m_ev = m_ev & ~wd;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask
  task automatic mdl;
    rd(CONFIG_ADDR, 32'h2, m_cfg);
    rd(RSTCTL_ADDR, 32'h80, m_rst);
    rd(IRQ_EN_ADDR, 32'h7, m_en);
    rd(IRQ_STAT_ADDR, 32'h7, m_ev);
    chk(irq, (m_ev & m_en) != 0);
  endtask
  task automatic pulse(input int sel);
    int n;
    n = 0;
    while ((sel ? reset_pin_oe : intrusion_pin_oe) !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    len = 0;
    while ((sel ? reset_pin_oe : intrusion_pin_oe) === 1'b1 && len < 200) begin
      @(posedge pclk);
      len++;
    end
    if (n == 10 || len == 200) bump();
  endtask
  task automatic scl_rise;
    int n;
    n = 0;
    while (scl !== 1'b0 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    while (scl !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) bump();
  endtask

  // Main sequence
  initial begin
    seed = 32'hb4b4;
    {n_mismatch, num_checks, m_cfg, m_rst, m_en, m_ev} = '0;
    {psel, penable, pwrite, paddr, pwdata, sda_drive_low, hdata} = '0;
    {nand_tree_select_in, nand_tree_result, frame, ev, ext_rst} = '0;
    {slave_addr_bit_high, slave_addr_bit_low_in} = 2'($random(seed));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(INTRCTL_ADDR, 32'hff, 0);
    rd(IRQ_CLR_ADDR, 32'hff, 0);
    rd(STATUS_ADDR, 32'h3, {slave_addr_bit_high, slave_addr_bit_low_in});
    chk(slave_addr_bits, {slave_addr_bit_high, slave_addr_bit_low_in});
    apb(1'b0, 8'h5c, 32'h0);
    chk({r[30:0], e}, 1);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(IRQ_EN_ADDR, d);
      wr(RSTCTL_ADDR, d);
      wr(CONFIG_ADDR, d & 32'h2);
      mdl();
    end
    wr(IRQ_CLR_ADDR, 32'h7);
    wr(IRQ_EN_ADDR, 32'h7);
    wr(CONFIG_ADDR, 32'h2);
    for (int k = 0; k < 2; k++) begin
      ev <= 1'b1;
      @(posedge pclk);
      ev <= 1'b0;
      repeat (6) @(posedge pclk);
      m_ev = m_ev | 1;
      rd(STATUS_ADDR, 32'h4, 32'h4);
      chk({int_oe, irq}, 2'b11);
      if (k == 0) wr(CONFIG_ADDR, 32'h42);
      else wr(INTRCTL_ADDR, 32'h80);
      pulse(0);
      chk(len, PLEN);
      m_ev = m_ev | 2;
      repeat (6) @(posedge pclk);
      rd(STATUS_ADDR, 32'h4, 32'h0);
      mdl();
    end
    wr(CONFIG_ADDR, 32'h0);
    repeat (3) @(posedge pclk);
    chk({int_oe, irq}, 2'b01);
    wr(IRQ_CLR_ADDR, 32'h7);
    wr(RSTCTL_ADDR, 32'h0);
    wr(CONFIG_ADDR, 32'h10);
    repeat (8) begin
      @(posedge pclk);
      chk(reset_pin_oe, 0);
    end
    wr(RSTCTL_ADDR, 32'h80);
    wr(CONFIG_ADDR, 32'h10);
    pulse(1);
    chk(len, PLEN);
    m_ev = m_ev | 4;
    repeat (6) @(posedge pclk);
    mdl();
    ext_rst <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(STATUS_ADDR, 32'h40, 32'h40);
    ext_rst <= 1'b0;
    repeat (6) @(posedge pclk);
    {m_cfg, m_rst, m_en, m_ev} = '0;
    mdl();
    nand_tree_select_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      nand_tree_result <= 1'($random(seed));
      repeat (6) @(posedge pclk);
      chk({slave_addr_bit_low_oe, slave_addr_bit_low_out, analog_out_enable},
          {1'b1, nand_tree_result, 1'b0});
    end
    rd(STATUS_ADDR, 32'h8, 32'h8);
    nand_tree_select_in <= 1'b0;
    repeat (6) @(posedge pclk);
    chk({slave_addr_bit_low_oe, analog_out_enable}, 2'b01);
    sda_drive_low <= 1'b1;
    repeat (5) @(posedge pclk);
    chk({sda_oe, sda_sampled}, 2'b10);
    sda_drive_low <= 1'b0;
    hdata <= 8'($random(seed));
    frame <= 1'b1;
    @(posedge pclk);
    for (int i = 7; i >= 0; i--) begin
      scl_rise();
      chk(sda_sampled, hdata[i]);
    end
    frame <= 1'b0;
    repeat (20) @(posedge pclk);
    summarize();
  end
endmodule // tb_top
